// file: cac_pkg.sv
/*
  Package of the charger and converter configuration bank: register
  offsets, field positions, reset values, carrier structs and states.
  Assumes it is compiled before every other file of the bank.
*/
`default_nettype none

package cac_pkg;

  // register offsets on the serial register port
  localparam logic [7:0] CAC_OFS_CHG_SECOND = 8'h05;
  localparam logic [7:0] CAC_OFS_CHG_THIRD  = 8'h06;
  localparam logic [7:0] CAC_OFS_CONV_CFG   = 8'h07;

  // charger_config_second field positions
  localparam int CAC_C2_DYN_TIMER   = 7;
  localparam int CAC_C2_PRE_VOLT    = 6;
  localparam int CAC_C2_CHG_VOLT_HI = 5;
  localparam int CAC_C2_CHG_VOLT_LO = 4;

  // charger_config_third field positions
  localparam int CAC_C3_ADP_SINK_DIS = 7;
  localparam int CAC_C3_PATH_THR_HI  = 6;
  localparam int CAC_C3_PATH_THR_LO  = 5;
  localparam int CAC_C3_PRE_TIME     = 4;
  localparam int CAC_C3_TERM_HI      = 3;
  localparam int CAC_C3_TERM_LO      = 2;
  localparam int CAC_C3_CHARGING     = 1;
  localparam int CAC_C3_USB_SINK_DIS = 0;

  // converter_config field positions
  localparam int CAC_CV_ENABLE  = 7;
  localparam int CAC_CV_START   = 6;
  localparam int CAC_CV_DONE    = 5;
  localparam int CAC_CV_REF_EN  = 4;
  localparam int CAC_CV_SEL_HI  = 3;
  localparam int CAC_CV_SEL_LO  = 0;

  // reset values, loaded at reset and on undervoltage lockout
  localparam logic [7:0] CAC_RST_CHG_SECOND = 8'hE0;
  localparam logic [7:0] CAC_RST_CHG_THIRD  = 8'h64;
  localparam logic [7:0] CAC_RST_CONV_CFG   = 8'h20;

  // input select codes that use the 6.0V full scale
  localparam logic [3:0] CAC_SEL_HIGH_FIRST = 4'h6;
  localparam logic [3:0] CAC_SEL_HIGH_LAST  = 4'hC;

  // pin synchroniser depth
  localparam int CAC_SYNC_STAGES = 3;

  // charger configuration handed to the charger logic
  typedef struct packed {
    logic       dyn_timer;
    logic       precharge_volt_hi;
    logic [1:0] charge_volt;
    logic       adapter_sink_dis;
    logic [1:0] path_threshold;
    logic       precharge_long;
    logic [1:0] term_factor;
    logic       usb_sink_dis;
  } cac_charger_cfg_t;

  // converter configuration handed to the analog front end
  typedef struct packed {
    logic       enable;
    logic       reference_en;
    logic [3:0] input_sel;
    logic       full_scale_high;
  } cac_converter_cfg_t;

  typedef enum logic [1:0] {
    CAC_CONV_IDLE = 2'b01,
    CAC_CONV_BUSY = 2'b10
  } cac_conv_state_t;

endpackage

`default_nettype wire

// file: cac_sync.sv
/*
  Three-stage pin synchroniser with agreement filter.
  Assumes asynchronous inputs; output moves only when stages two and
  three agree.
*/
`timescale 1ns/100ps
`default_nettype none

module cac_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pin,
  output var  logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  if (WIDTH < 1) begin : g_chk
    $error("cac_sync needs at least one bit");
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      level <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          level[i] <= s3_q[i];
        end
      end
    end
  end

endmodule

`default_nettype wire

// file: cac_sink.sv
/*
  Input-pin current sink control for one supply input.
  Assumes a synchronised voltage-present level and the disable bit.
*/
`timescale 1ns/100ps
`default_nettype none

module cac_sink (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic voltage_present,
  input  wire logic sink_disable,
  output var  logic sink_en
);

  // sink only keeps a bare pin from floating
  always_ff @(posedge clk) begin
    if (rst) begin
      sink_en <= 1'b0;
    end else begin
      sink_en <= !sink_disable && !voltage_present;
    end
  end

endmodule

`default_nettype wire

// file: cac_regs.sv
/*
  Charger and converter configuration register bank.
  Assumes a serial front end on the same clock delivering byte
  register strobes, analog status levels on pins, and a converter
  core that pulses done on this clock.
*/
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - dynamic timer bit halves safety timer rate while thermal or path loop runs.
// - precharge voltage bit picks 2.5V (0) or 2.9V (1) fast-charge threshold.
// - charge voltage field picks 4.10, 4.15, 4.20 or 4.25V.
// - adapter sink enabled when its disable bit is 0 and no voltage there; the bank holds it off during undervoltage lockout.
// - USB sink enabled when its disable bit is 0 and no voltage there; the bank holds it off during undervoltage lockout.
// - a sink turns off once voltage is seen on its pin.
// - path threshold field picks 3.5, 3.75, 4.25 or 4.50 V.
// - precharge time bit picks 30 min (0) or 60 min (1).
// - termination factor field picks 0.04, 0.1, 0.15 or 0.2.
// - read-only charging bit shows charger activity; writes ignored.
// - converter enable bit powers the converter; default 0.
// - host writes start 1; device clears it when conversion completes.
// - read-only end-of-conversion flag is 1 when done; default 1.
// - reference enable bit switches reference regulator; default 0.
// - undervoltage lockout reloads every writable field with its default.
// - input select routes source; low sources 2.25V, supply sources 6.0V.
module cac_regs (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  input  wire logic [7:0]                  reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  output var  logic [7:0]                  reg_rdata,
  output var  logic                        reg_rvalid,
  input  wire logic                        undervoltage_lockout_pin,
  input  wire logic                        charging_pin,
  input  wire logic                        thermal_loop_pin,
  input  wire logic                        power_path_loop_pin,
  input  wire logic                        adapter_input_pin_present,
  input  wire logic                        usb_input_present,
  input  wire logic                        timer_base_tick,
  input  wire logic                        adc_done,
  output var  logic                        timer_tick,
  output var  cac_pkg::cac_charger_cfg_t   charger_cfg,
  output var  cac_pkg::cac_converter_cfg_t converter_cfg,
  output var  logic                        adc_start,
  output var  logic                        conversion_busy,
  output var  logic                        adapter_sink_en,
  output var  logic                        usb_sink_en
);
  import cac_pkg::*;

  localparam int SYNC_W = 6;

  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_lvl;
  logic              undervoltage_lockout_s;
  logic              charging_s;
  logic              thermal_s;
  logic              path_s;
  logic              adapter_s;
  logic              usb_s;

  logic              wr_c2;
  logic              wr_c3;
  logic              wr_cv;
  logic              start_req;
  logic              reload;

  logic              dyn_q;
  logic              pre_volt_q;
  logic [1:0]        chg_volt_q;
  logic              adp_dis_q;
  logic [1:0]        path_thr_q;
  logic              pre_time_q;
  logic [1:0]        term_q;
  logic              usb_dis_q;
  logic              conv_en_q;
  logic              ref_en_q;
  logic [3:0]        sel_q;
  logic              start_q;
  logic              done_q;
  logic              half_q;
  logic              slow;
  logic [7:0]        rd_word;
  logic              fsh_q;

  cac_conv_state_t   state_q;

  if (CAC_SYNC_STAGES != 3) begin : g_chk
    $error("cac_regs expects a three-stage pin synchroniser");
  end

  // slices below assume these field widths
  if ((CAC_C2_CHG_VOLT_HI - CAC_C2_CHG_VOLT_LO) != 1 ||
      (CAC_C3_PATH_THR_HI - CAC_C3_PATH_THR_LO) != 1 ||
      (CAC_C3_TERM_HI - CAC_C3_TERM_LO) != 1 ||
      (CAC_CV_SEL_HI - CAC_CV_SEL_LO) != 3) begin : g_fld
    $error("cac_regs field positions do not fit field widths");
  end

  // all asynchronous status pins through one filtered synchroniser
  assign pins_raw = {undervoltage_lockout_pin, charging_pin,
                     thermal_loop_pin, power_path_loop_pin,
                     adapter_input_pin_present, usb_input_present};

  cac_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk   (clk),
    .rst   (rst),
    .pin   (pins_raw),
    .level (pins_lvl)
  );

  assign undervoltage_lockout_s     = pins_lvl[5];
  assign charging_s = pins_lvl[4];
  assign thermal_s  = pins_lvl[3];
  assign path_s     = pins_lvl[2];
  assign adapter_s  = pins_lvl[1];
  assign usb_s      = pins_lvl[0];

  // write decode
  assign wr_c2  = reg_wr && (reg_addr == CAC_OFS_CHG_SECOND);
  assign wr_c3  = reg_wr && (reg_addr == CAC_OFS_CHG_THIRD);
  assign wr_cv  = reg_wr && (reg_addr == CAC_OFS_CONV_CFG);
  assign reload = rst || undervoltage_lockout_s;

  // start only honoured when the same write leaves the converter on
  assign start_req = wr_cv && reg_wdata[CAC_CV_START]
                     && reg_wdata[CAC_CV_ENABLE]
                     && (state_q == CAC_CONV_IDLE) && !undervoltage_lockout_s;

  // charger_config_second
  always_ff @(posedge clk) begin
    if (reload) begin
      dyn_q      <= CAC_RST_CHG_SECOND[CAC_C2_DYN_TIMER];
      pre_volt_q <= CAC_RST_CHG_SECOND[CAC_C2_PRE_VOLT];
      chg_volt_q <= CAC_RST_CHG_SECOND[CAC_C2_CHG_VOLT_HI:
                                       CAC_C2_CHG_VOLT_LO];
    end else if (wr_c2) begin
      dyn_q      <= reg_wdata[CAC_C2_DYN_TIMER];
      pre_volt_q <= reg_wdata[CAC_C2_PRE_VOLT];
      chg_volt_q <= reg_wdata[CAC_C2_CHG_VOLT_HI:
                              CAC_C2_CHG_VOLT_LO];
    end
  end

  // charger_config_third; charging bit is not stored
  always_ff @(posedge clk) begin
    if (reload) begin
      adp_dis_q  <= CAC_RST_CHG_THIRD[CAC_C3_ADP_SINK_DIS];
      path_thr_q <= CAC_RST_CHG_THIRD[CAC_C3_PATH_THR_HI:
                                      CAC_C3_PATH_THR_LO];
      pre_time_q <= CAC_RST_CHG_THIRD[CAC_C3_PRE_TIME];
      term_q     <= CAC_RST_CHG_THIRD[CAC_C3_TERM_HI:CAC_C3_TERM_LO];
      usb_dis_q  <= CAC_RST_CHG_THIRD[CAC_C3_USB_SINK_DIS];
    end else if (wr_c3) begin
      adp_dis_q  <= reg_wdata[CAC_C3_ADP_SINK_DIS];
      path_thr_q <= reg_wdata[CAC_C3_PATH_THR_HI:
                              CAC_C3_PATH_THR_LO];
      pre_time_q <= reg_wdata[CAC_C3_PRE_TIME];
      term_q     <= reg_wdata[CAC_C3_TERM_HI:CAC_C3_TERM_LO];
      usb_dis_q  <= reg_wdata[CAC_C3_USB_SINK_DIS];
    end
  end

  // converter_config writable fields
  always_ff @(posedge clk) begin
    if (reload) begin
      conv_en_q <= CAC_RST_CONV_CFG[CAC_CV_ENABLE];
      ref_en_q  <= CAC_RST_CONV_CFG[CAC_CV_REF_EN];
      sel_q     <= CAC_RST_CONV_CFG[CAC_CV_SEL_HI:CAC_CV_SEL_LO];
    end else if (wr_cv) begin
      conv_en_q <= reg_wdata[CAC_CV_ENABLE];
      ref_en_q  <= reg_wdata[CAC_CV_REF_EN];
      sel_q     <= reg_wdata[CAC_CV_SEL_HI:CAC_CV_SEL_LO];
    end
  end

  // conversion sequencer
  always_ff @(posedge clk) begin
    if (reload) begin
      state_q <= CAC_CONV_IDLE;
    end else begin
      case (state_q)
        CAC_CONV_IDLE: begin
          if (start_req) begin
            state_q <= CAC_CONV_BUSY;
          end
        end
        CAC_CONV_BUSY: begin
          // disable while busy aborts; done stays low
          if (adc_done || !conv_en_q) begin
            state_q <= CAC_CONV_IDLE;
          end
        end
        default: begin
          state_q <= CAC_CONV_IDLE;
        end
      endcase
    end
  end

  // self-clearing start bit
  always_ff @(posedge clk) begin
    if (reload) begin
      start_q <= CAC_RST_CONV_CFG[CAC_CV_START];
    end else if (start_req) begin
      start_q <= 1'b1;
    end else if (state_q == CAC_CONV_BUSY
                 && (adc_done || !conv_en_q)) begin
      start_q <= 1'b0;
    end
  end

  // end-of-conversion flag; finish beats abort
  always_ff @(posedge clk) begin
    if (reload) begin
      done_q <= CAC_RST_CONV_CFG[CAC_CV_DONE];
    end else if (state_q == CAC_CONV_BUSY && adc_done) begin
      done_q <= 1'b1;
    end else if (start_req) begin
      done_q <= 1'b0;
    end
  end

  // start strobe to the converter core
  always_ff @(posedge clk) begin
    if (rst) begin
      adc_start <= 1'b0;
    end else begin
      adc_start <= start_req;
    end
  end

  assign conversion_busy = (state_q == CAC_CONV_BUSY);

  // safety timer tick scaling
  assign slow = dyn_q && (thermal_s || path_s);

  always_ff @(posedge clk) begin
    if (rst) begin
      half_q <= 1'b0;
    end else if (!slow) begin
      half_q <= 1'b0;
    end else if (timer_base_tick) begin
      half_q <= !half_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      timer_tick <= 1'b0;
    end else begin
      timer_tick <= timer_base_tick && (!slow || half_q);
    end
  end

  // input-pin current sinks
  cac_sink u_sink_adapter (
    .clk             (clk),
    .rst             (reload),
    .voltage_present (adapter_s),
    .sink_disable    (adp_dis_q),
    .sink_en         (adapter_sink_en)
  );

  cac_sink u_sink_usb (
    .clk             (clk),
    .rst             (reload),
    .voltage_present (usb_s),
    .sink_disable    (usb_dis_q),
    .sink_en         (usb_sink_en)
  );

  // configuration towards charger and converter
  assign charger_cfg.dyn_timer         = dyn_q;
  assign charger_cfg.precharge_volt_hi = pre_volt_q;
  assign charger_cfg.charge_volt       = chg_volt_q;
  assign charger_cfg.adapter_sink_dis  = adp_dis_q;
  assign charger_cfg.path_threshold    = path_thr_q;
  assign charger_cfg.precharge_long    = pre_time_q;
  assign charger_cfg.term_factor       = term_q;
  assign charger_cfg.usb_sink_dis      = usb_dis_q;

  assign converter_cfg.enable       = conv_en_q;
  assign converter_cfg.reference_en = ref_en_q;
  assign converter_cfg.input_sel    = sel_q;
  assign converter_cfg.full_scale_high = fsh_q;

  // supply and battery sources take the wide range
  always_ff @(posedge clk) begin
    if (reload) begin
      fsh_q <= 1'b0;
    end else begin
      fsh_q <= (sel_q >= CAC_SEL_HIGH_FIRST)
               && (sel_q <= CAC_SEL_HIGH_LAST);
    end
  end

  // read mux; reserved and unmapped read zero
  always_comb begin
    rd_word = 8'h00;
    case (reg_addr)
      CAC_OFS_CHG_SECOND: begin
        rd_word[CAC_C2_DYN_TIMER] = dyn_q;
        rd_word[CAC_C2_PRE_VOLT]  = pre_volt_q;
        rd_word[CAC_C2_CHG_VOLT_HI:CAC_C2_CHG_VOLT_LO] = chg_volt_q;
      end
      CAC_OFS_CHG_THIRD: begin
        rd_word[CAC_C3_ADP_SINK_DIS] = adp_dis_q;
        rd_word[CAC_C3_PATH_THR_HI:CAC_C3_PATH_THR_LO] = path_thr_q;
        rd_word[CAC_C3_PRE_TIME]     = pre_time_q;
        rd_word[CAC_C3_TERM_HI:CAC_C3_TERM_LO] = term_q;
        rd_word[CAC_C3_CHARGING]     = charging_s;
        rd_word[CAC_C3_USB_SINK_DIS] = usb_dis_q;
      end
      CAC_OFS_CONV_CFG: begin
        rd_word[CAC_CV_ENABLE] = conv_en_q;
        rd_word[CAC_CV_START]  = start_q;
        rd_word[CAC_CV_DONE]   = done_q;
        rd_word[CAC_CV_REF_EN] = ref_en_q;
        rd_word[CAC_CV_SEL_HI:CAC_CV_SEL_LO] = sel_q;
      end
      default: begin
        rd_word = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_word;
      end
    end
  end

endmodule

`default_nettype wire

// file: cac_regs_asserts.sv
/*
  Port checker of the charger and converter configuration bank.
  Assumes it is bound to cac_regs and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none

module cac_regs_asserts (
  input wire logic                        clk,
  input wire logic                        rst,
  input wire logic                        reg_rd,
  input wire logic                        reg_rvalid,
  input wire logic                        undervoltage_lockout_pin,
  input wire logic                        adapter_input_pin_present,
  input wire logic                        usb_input_present,
  input wire logic                        timer_base_tick,
  input wire logic                        adc_done,
  input wire logic                        timer_tick,
  input wire cac_pkg::cac_charger_cfg_t   charger_cfg,
  input wire cac_pkg::cac_converter_cfg_t converter_cfg,
  input wire logic                        adc_start,
  input wire logic                        conversion_busy,
  input wire logic                        adapter_sink_en,
  input wire logic                        usb_sink_en
);
  import cac_pkg::*;

  logic sel_high;
  assign sel_high = converter_cfg.input_sel >= CAC_SEL_HIGH_FIRST &&
                    converter_cfg.input_sel <= CAC_SEL_HIGH_LAST;

  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_conv_end;
    conversion_busy && adc_done;
  endsequence
  sequence s_lockout_held;
    undervoltage_lockout_pin [*8];
  endsequence
  sequence s_nominal_tick;
    !charger_cfg.dyn_timer && !$past(charger_cfg.dyn_timer) &&
      timer_base_tick;
  endsequence

  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe not answered");
  a_start_single: assert property (adc_start |=> !adc_start)
    else $error("start pulse longer than one cycle");
  a_start_busy: assert property (
    adc_start |-> conversion_busy && converter_cfg.enable)
    else $error("start without busy or enable");
  a_finish_idle: assert property (s_conv_end |=> !conversion_busy)
    else $error("busy after converter done");
  a_adapter_off: assert property (
    adapter_input_pin_present [*8] |-> !adapter_sink_en)
    else $error("adapter sink on with voltage present");
  a_usb_off: assert property (usb_input_present [*8] |-> !usb_sink_en)
    else $error("usb sink on with voltage present");
  a_adapter_dis: assert property (
    charger_cfg.adapter_sink_dis |=> !adapter_sink_en)
    else $error("adapter sink on while disabled");
  a_usb_dis: assert property (charger_cfg.usb_sink_dis |=> !usb_sink_en)
    else $error("usb sink on while disabled");
  a_tick_nominal: assert property (s_nominal_tick |=> timer_tick)
    else $error("nominal tick dropped");
  a_tick_cause: assert property (!timer_base_tick |=> !timer_tick)
    else $error("tick without base tick");
  a_scale_range: assert property (
    1'b1 |=> converter_cfg.full_scale_high == $past(sel_high))
    else $error("full scale range wrong for input select");
  a_lockout_load: assert property (
    s_lockout_held |-> charger_cfg == 11'h732 && !converter_cfg.enable)
    else $error("defaults not held during lockout");
endmodule

bind cac_regs cac_regs_asserts chk_u (
  .clk                       (clk),
  .rst                       (rst),
  .reg_rd                    (reg_rd),
  .reg_rvalid                (reg_rvalid),
  .undervoltage_lockout_pin  (undervoltage_lockout_pin),
  .adapter_input_pin_present (adapter_input_pin_present),
  .usb_input_present         (usb_input_present),
  .timer_base_tick           (timer_base_tick),
  .adc_done                  (adc_done),
  .timer_tick                (timer_tick),
  .charger_cfg               (charger_cfg),
  .converter_cfg             (converter_cfg),
  .adc_start                 (adc_start),
  .conversion_busy           (conversion_busy),
  .adapter_sink_en           (adapter_sink_en),
  .usb_sink_en               (usb_sink_en)
);

`default_nettype wire

// file: cac_host_model.sv
/*
  Host side of the register port: byte writes, reads, done polling.
  Assumes the bank answers a read exactly one cycle after the strobe.
*/
`timescale 1ns/100ps
`default_nettype none

module cac_host_model (
  input  wire logic       clk,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  import cac_pkg::*;

  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // idle bus shows inverted last value, never a stale copy
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge clk);
    #1;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask

  // result is {valid, data}
  task automatic rd(input logic [7:0] a, output logic [8:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clk);
    #1;
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = {reg_rvalid, reg_rdata};
  endtask

  task automatic poll_done(output logic [8:0] d);
    for (int i = 0; i < 64; i++) begin
      rd(CAC_OFS_CONV_CFG, d);
      if (d[CAC_CV_DONE] === 1'b1) break;
    end
  endtask
endmodule

`default_nettype wire

// file: cac_tb.sv
/*
  Self-checking bench of the configuration bank with host model and
  a behavioural converter core. Assumes the bank as top under test.
*/
`timescale 1ns/100ps
`default_nettype none

module tb;
  import cac_pkg::*;

  logic               clk, rst, reg_wr, reg_rd, rvalid, tick, busy;
  logic               lock, chg, therm, path, adp, usb, base, adc_done;
  logic               adc_start, adp_sink, usb_sink;
  logic [7:0]         addr, wdata, rdata;
  logic [8:0]         rv;
  cac_charger_cfg_t   ccfg;
  cac_converter_cfg_t vcfg;
  int                 n_fail = 0;
  int                 n_compared = 0;
  int                 cyc = 0;
  int                 done_delay = 0;
  int                 dcnt = 0;
  int                 ticks = 0;

  cac_regs dut_u (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .undervoltage_lockout_pin(lock),
    .charging_pin(chg), .thermal_loop_pin(therm),
    .power_path_loop_pin(path), .adapter_input_pin_present(adp),
    .usb_input_present(usb), .timer_base_tick(base), .adc_done(adc_done),
    .timer_tick(tick), .charger_cfg(ccfg), .converter_cfg(vcfg),
    .adc_start(adc_start), .conversion_busy(busy),
    .adapter_sink_en(adp_sink), .usb_sink_en(usb_sink));

  cac_host_model host_u (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
    .reg_rvalid(rvalid));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // converter core answers done_delay cycles after start; 0 never answers
  always @(posedge clk) begin
    #1;
    adc_done = (dcnt == 1);
    if (dcnt != 0) dcnt = dcnt - 1;
    if (adc_start) dcnt = done_delay;
    if (tick) ticks++;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [10:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host_u.rd(a, rv);
    chk("read", {3'b001, e}, {2'b00, rv});
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic t_fields();
    logic [1:0] v;
    rchk(CAC_OFS_CHG_SECOND, 8'hE0);
    rchk(CAC_OFS_CHG_THIRD, 8'h64);
    rchk(CAC_OFS_CONV_CFG, 8'h20);
    for (int i = 0; i < 4; i++) begin
      v = 2'(i);
      host_u.wr(CAC_OFS_CHG_SECOND, {v[0], v[1], v, 4'hF});
      host_u.wr(CAC_OFS_CHG_THIRD, {v[1], v, v[0], v, 1'b1, v[0]});
      chk("cfg", {v[0], v[1], v, v[1], v, v[0], v, v[0]}, ccfg);
      rchk(CAC_OFS_CHG_SECOND, {v[0], v[1], v, 4'h0});
      rchk(CAC_OFS_CHG_THIRD, {v[1], v, v[0], v, 1'b0, v[0]});
    end
    chg = 1'b1;
    wt(8);
    rchk(CAC_OFS_CHG_THIRD, 8'hFF);
    chg = 1'b0;
    host_u.wr(8'h08, 8'hFF);
    rchk(8'h08, 8'h00);
    rchk(8'h04, 8'h00);
  endtask

  task automatic t_conv();
    done_delay = 12;
    host_u.wr(CAC_OFS_CONV_CFG, 8'h47);
    rchk(CAC_OFS_CONV_CFG, 8'h27);
    chk("scale", 11'h001, {10'h000, vcfg.full_scale_high});
    host_u.wr(CAC_OFS_CONV_CFG, 8'hDD);
    rchk(CAC_OFS_CONV_CFG, 8'hDD);
    chk("busy", 11'h0FA, {3'b000, busy, vcfg});
    host_u.poll_done(rv);
    chk("finish", 11'h1BD, {2'b00, rv});
    done_delay = 0;
    host_u.wr(CAC_OFS_CONV_CFG, 8'hC0);
    host_u.wr(CAC_OFS_CONV_CFG, 8'h00);
    rchk(CAC_OFS_CONV_CFG, 8'h00);
  endtask

  task automatic t_sinks();
    host_u.wr(CAC_OFS_CHG_THIRD, 8'h64);
    adp = 1'b0;
    wt(10);
    chk("sinks", 11'h002, {9'h000, adp_sink, usb_sink});
    adp = 1'b1;
    usb = 1'b0;
    wt(10);
    chk("sinks", 11'h001, {9'h000, adp_sink, usb_sink});
    host_u.wr(CAC_OFS_CHG_THIRD, 8'hE5);
    adp = 1'b0;
    wt(10);
    chk("sinks", 11'h000, {9'h000, adp_sink, usb_sink});
    adp = 1'b1;
    usb = 1'b1;
  endtask

  task automatic ticks4(input int e);
    wt(8);
    ticks = 0;
    repeat (4) begin
      base = 1'b1;
      wt(1);
      base = 1'b0;
      wt(3);
    end
    wt(2);
    chk("ticks", 11'(e), 11'(ticks));
  endtask

  task automatic t_timer();
    host_u.wr(CAC_OFS_CHG_SECOND, 8'h80);
    therm = 1'b1;
    ticks4(2);
    therm = 1'b0;
    path = 1'b1;
    ticks4(2);
    host_u.wr(CAC_OFS_CHG_SECOND, 8'h00);
    ticks4(4);
    path = 1'b0;
  endtask

  task automatic t_lockout();
    host_u.wr(CAC_OFS_CHG_THIRD, 8'h9A);
    host_u.wr(CAC_OFS_CONV_CFG, 8'h9F);
    lock = 1'b1;
    wt(6);
    host_u.wr(CAC_OFS_CHG_SECOND, 8'h10);
    wt(4);
    lock = 1'b0;
    wt(6);
    rchk(CAC_OFS_CHG_SECOND, 8'hE0);
    rchk(CAC_OFS_CHG_THIRD, 8'h64);
    rchk(CAC_OFS_CONV_CFG, 8'h20);
  endtask

  initial begin
    rst = 1'b1;
    lock = 1'b0;
    chg = 1'b0;
    therm = 1'b0;
    path = 1'b0;
    adp = 1'b1;
    usb = 1'b1;
    base = 1'b0;
    adc_done = 1'b0;
    wt(4);
    rst = 1'b0;
    t_fields();
    t_conv();
    t_sinks();
    t_timer();
    t_lockout();
    stop_test();
  end
endmodule

`default_nettype wire
